// ---- rtl/bbu_branch.sv ----
// branch decision and target for the relative branches
module bbu_branch
  import bbu_pkg::*;
(
  // operand side
  bbu_ex_if.brancher ex
);

  // condition and target are pure functions of op, flags, pc and offset
  always_comb
  begin
    ex.br_take = is_branch(ex.op) && branch_cond(ex.op, ex.flags);
    ex.br_pc = pc_target(ex.pc, ex.ofs);
  end

endmodule : bbu_branch

// ---- rtl/bbu_ex_if.sv ----
// operands out to the helpers and their results back to the core
interface bbu_ex_if;
  import bbu_pkg::*;
  bbu_op_t op;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] flags;
  logic [PC_W-1:0] pc;
  logic [OFS_W-1:0] ofs;
  logic [DATA_W-1:0] sh_res;
  logic [DATA_W-1:0] sh_flags;
  logic br_take;
  logic [PC_W-1:0] br_pc;

  modport core (output op, opnd, flags, pc, ofs, input sh_res, sh_flags, br_take, br_pc);
  modport shifter (input op, opnd, flags, output sh_res, sh_flags);
  modport brancher (input op, flags, pc, ofs, output br_take, br_pc);
endinterface : bbu_ex_if

// ---- rtl/bbu_pkg.sv ----
// Notes on behaviour
// - carry/negative branches jump by offset plus one
// - signed ge branch jumps when N^V is 0
// - signed less branch jumps when N^V is 1
// - half carry one branch jumps, flags kept
// - half carry zero branch jumps, flags kept
// - transfer flag one branch jumps, flags kept
// - irq on branch jumps when I is 1
// - irq off branch jumps when I is 0
// - io bit set writes one, two cycles
// - io bit clear writes zero, two cycles
// - shifts set Z C N V in one cycle
// - rotate left moves carry in and out
// - rotate right moves carry in and out
// - bit store copies register bit to T
package bbu_pkg;

  // datapath widths
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int OFS_W = 7;

  // positions inside the status flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // values after reset
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

  // cycle counts of the multi-cycle forms
  localparam int BRANCH_TAKEN_CYCLES = 2;
  localparam int IO_BIT_CYCLES = 2;

  // operations handled by this slice
  typedef enum logic [4:0] {
    OP_BRANCH_CARRY_CLEAR = 5'h00,
    OP_BRANCH_UNSIGNED_LOWER = 5'h01,
    OP_BRANCH_NEGATIVE = 5'h02,
    OP_BRANCH_POSITIVE = 5'h03,
    OP_BRANCH_SIGNED_GE = 5'h04,
    OP_BRANCH_SIGNED_LESS = 5'h05,
    OP_BRANCH_HALFCARRY_ONE = 5'h06,
    OP_BRANCH_HALFCARRY_ZERO = 5'h07,
    OP_BRANCH_TRANSFER_FLAG_ONE = 5'h08,
    OP_BRANCH_IRQ_ON = 5'h09,
    OP_BRANCH_IRQ_OFF = 5'h0A,
    OP_IO_BIT_SET = 5'h10,
    OP_IO_BIT_CLEAR = 5'h11,
    OP_LOGICAL_LEFT_SHIFT = 5'h12,
    OP_LOGICAL_RIGHT_SHIFT = 5'h13,
    OP_ROTATE_LEFT_VIA_CARRY = 5'h14,
    OP_ROTATE_RIGHT_VIA_CARRY = 5'h15,
    OP_ARITHMETIC_RIGHT_SHIFT = 5'h16,
    OP_NIBBLE_SWAP = 5'h17,
    OP_STATUS_FLAG_SET = 5'h18,
    OP_STATUS_FLAG_CLEAR = 5'h19,
    OP_BIT_TO_TRANSFER_FLAG = 5'h1A
  } bbu_op_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BRANCH = 3'h2,
    ST_IO = 3'h4
  } bbu_state_t;

  // true for every conditional branch code
  function automatic logic is_branch(input bbu_op_t op);
    is_branch = (op <= OP_BRANCH_IRQ_OFF);
  endfunction : is_branch

  // branch condition against the current flags
  function automatic logic branch_cond(input bbu_op_t op, input logic [DATA_W-1:0] f);
    case (op)
      OP_BRANCH_CARRY_CLEAR: branch_cond = !f[FLAG_C];
      OP_BRANCH_UNSIGNED_LOWER: branch_cond = f[FLAG_C];
      OP_BRANCH_NEGATIVE: branch_cond = f[FLAG_N];
      OP_BRANCH_POSITIVE: branch_cond = !f[FLAG_N];
      OP_BRANCH_SIGNED_GE: branch_cond = !(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_SIGNED_LESS: branch_cond = f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_HALFCARRY_ONE: branch_cond = f[FLAG_H];
      OP_BRANCH_HALFCARRY_ZERO: branch_cond = !f[FLAG_H];
      OP_BRANCH_TRANSFER_FLAG_ONE: branch_cond = f[FLAG_T];
      OP_BRANCH_IRQ_ON: branch_cond = f[FLAG_I];
      OP_BRANCH_IRQ_OFF: branch_cond = !f[FLAG_I];
      default: branch_cond = 1'b0;
    endcase
  endfunction : branch_cond

  // pc plus signed word offset plus one
  function automatic logic [PC_W-1:0] pc_target(input logic [PC_W-1:0] pc,
                                                input logic [OFS_W-1:0] k);
    pc_target = pc + {{(PC_W - OFS_W){k[OFS_W-1]}}, k} + PC_W'(1);
  endfunction : pc_target

  // one-hot byte mask for a bit select
  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] sel);
    bit_mask = DATA_W'(1) << sel;
  endfunction : bit_mask

endpackage : bbu_pkg

// ---- rtl/bbu_shifter.sv ----
// shift, rotate and swap results with their new flags
module bbu_shifter
  import bbu_pkg::*;
(
  // operand side
  bbu_ex_if.shifter ex
);

  logic [DATA_W-1:0] res; // shifted byte
  logic cout; // bit shifted out

  // pick the result; swap keeps the old carry and flags
  always_comb
  begin
    res = ex.opnd;
    cout = ex.flags[FLAG_C];
    case (ex.op)
      OP_LOGICAL_LEFT_SHIFT:
      begin
        res = {ex.opnd[6:0], 1'b0};
        cout = ex.opnd[7];
      end
      OP_LOGICAL_RIGHT_SHIFT:
      begin
        res = {1'b0, ex.opnd[7:1]};
        cout = ex.opnd[0];
      end
      OP_ARITHMETIC_RIGHT_SHIFT:
      begin
        res = {ex.opnd[7], ex.opnd[7:1]};
        cout = ex.opnd[0];
      end
      OP_ROTATE_LEFT_VIA_CARRY:
      begin
        res = {ex.opnd[6:0], ex.flags[FLAG_C]};
        cout = ex.opnd[7];
      end
      OP_ROTATE_RIGHT_VIA_CARRY:
      begin
        res = {ex.flags[FLAG_C], ex.opnd[7:1]};
        cout = ex.opnd[0];
      end
      OP_NIBBLE_SWAP: res = {ex.opnd[3:0], ex.opnd[7:4]};
      default: res = ex.opnd;
    endcase
  end

  // flag update: Z C N V for shifts, V is N xor C; S is left alone
  always_comb
  begin
    ex.sh_res = res;
    ex.sh_flags = ex.flags;
    if (ex.op != OP_NIBBLE_SWAP)
    begin
      ex.sh_flags[FLAG_Z] = (res == '0);
      ex.sh_flags[FLAG_C] = cout;
      ex.sh_flags[FLAG_N] = res[7];
      ex.sh_flags[FLAG_V] = res[7] ^ cout;
    end
  end

endmodule : bbu_shifter

// ---- rtl/bbu_top.sv ----
// branch and bit operation slice of the core
module bbu_top
  import bbu_pkg::*;
#(
  parameter int IO_ADDR_W = 5, // width of the io register address
  parameter int REG_IDX_W = 5 // width of a working register index
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // instruction issue
  input wire logic op_valid_i,
  input wire bbu_op_t op_i,
  input wire logic [OFS_W-1:0] offset_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [REG_IDX_W-1:0] dst_idx_i,
  input wire logic [DATA_W-1:0] work_data_i,
  input wire logic [IO_ADDR_W-1:0] io_addr_i,
  // io read data and outside flag loads
  input wire logic [DATA_W-1:0] io_rdata_i,
  input wire logic flags_we_i,
  input wire logic [DATA_W-1:0] flags_wdata_i,
  // sequencer state
  output logic busy_o,
  output logic done_o,
  output logic [PC_W-1:0] pc_o,
  output logic [DATA_W-1:0] status_o,
  // working register write back
  output logic wr_en_o,
  output logic [REG_IDX_W-1:0] wr_idx_o,
  output logic [DATA_W-1:0] wr_data_o,
  // io space access
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [IO_ADDR_W-1:0] io_addr_o,
  output logic [DATA_W-1:0] io_wdata_o
);

  // every flip-flop of the slice
  typedef struct packed {
    bbu_state_t st; // sequencer state
    logic busy; // second cycle in flight
    logic done; // instruction retired
    logic [PC_W-1:0] pc; // program counter
    logic [DATA_W-1:0] flags; // status flags register
    logic wr_en; // write back strobe
    logic [REG_IDX_W-1:0] wr_idx; // write back index
    logic [DATA_W-1:0] wr_data; // write back value
    logic io_rd; // io read strobe
    logic io_wr; // io write strobe
    logic [IO_ADDR_W-1:0] io_addr; // io address, held for the write
    logic [DATA_W-1:0] io_wdata; // io write value
    logic [2:0] bit_sel; // io bit kept for the second cycle
    logic io_set; // set rather than clear
    logic [PC_W-1:0] tgt; // taken branch target
  } bbu_top_state_t;

  localparam bbu_top_state_t STATE_RESET = '{
    st: ST_IDLE,
    busy: 1'b0,
    done: 1'b0,
    pc: PC_RESET,
    flags: STATUS_RESET,
    wr_en: 1'b0,
    wr_idx: '0,
    wr_data: '0,
    io_rd: 1'b0,
    io_wr: 1'b0,
    io_addr: '0,
    io_wdata: '0,
    bit_sel: 3'h0,
    io_set: 1'b0,
    tgt: PC_RESET
  };

  bbu_top_state_t r; // registered state
  bbu_top_state_t next_r; // state for the next edge

  bbu_ex_if ex (); // link to the helpers

  // helpers see the issuing instruction and the live flags
  assign ex.op = op_i;
  assign ex.opnd = work_data_i;
  assign ex.flags = r.flags;
  assign ex.pc = r.pc;
  assign ex.ofs = offset_i;

  // shift, rotate and swap unit
  bbu_shifter u_shifter (
    .ex(ex.shifter)
  );

  // branch decision unit
  bbu_branch u_branch (
    .ex(ex.brancher)
  );

  // next state; issue is taken only in idle, so busy is the stall
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.wr_en = 1'b0;
    next_r.io_rd = 1'b0;
    next_r.io_wr = 1'b0;
    // outside loads first so an own flag update in the same cycle wins
    if (flags_we_i)
    begin
      next_r.flags = flags_wdata_i;
    end
    case (r.st)
      ST_IDLE:
      begin
        if (op_valid_i)
        begin
          if (is_branch(op_i))
          begin
            // flags are never touched by a branch
            if (ex.br_take)
            begin
              next_r.st = ST_BRANCH;
              next_r.busy = 1'b1;
              next_r.tgt = ex.br_pc;
            end
            else
            begin
              next_r.pc = r.pc + PC_W'(1);
              next_r.done = 1'b1;
            end
          end
          else
          begin
            next_r.pc = r.pc + PC_W'(1);
            next_r.done = 1'b1;
            case (op_i)
              OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
              begin
                // read first, write on the second cycle
                next_r.st = ST_IO;
                next_r.busy = 1'b1;
                next_r.done = 1'b0;
                next_r.pc = r.pc;
                next_r.io_rd = 1'b1;
                next_r.io_addr = io_addr_i;
                next_r.bit_sel = bit_sel_i;
                next_r.io_set = (op_i == OP_IO_BIT_SET);
              end
              OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ARITHMETIC_RIGHT_SHIFT,
              OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY, OP_NIBBLE_SWAP:
              begin
                next_r.wr_en = 1'b1;
                next_r.wr_idx = dst_idx_i;
                next_r.wr_data = ex.sh_res;
                next_r.flags = ex.sh_flags;
              end
              OP_STATUS_FLAG_SET: next_r.flags = r.flags | bit_mask(bit_sel_i);
              OP_STATUS_FLAG_CLEAR: next_r.flags = r.flags & ~bit_mask(bit_sel_i);
              OP_BIT_TO_TRANSFER_FLAG: next_r.flags[FLAG_T] = work_data_i[bit_sel_i];
              default:
              begin
                // unlisted codes, 0x0B-0x0F and those above the bit store, are dropped: no retire and no pc step
                next_r.done = 1'b0;
                next_r.pc = r.pc;
              end
            endcase
          end
        end
      end
      ST_BRANCH:
      begin
        // second cycle of a taken branch loads the target
        next_r.pc = r.tgt;
        next_r.done = 1'b1;
        next_r.busy = 1'b0;
        next_r.st = ST_IDLE;
      end
      ST_IO:
      begin
        // read data stands while the read strobe is high
        next_r.io_wr = 1'b1;
        if (r.io_set)
        begin
          next_r.io_wdata = io_rdata_i | bit_mask(r.bit_sel);
        end
        else
        begin
          next_r.io_wdata = io_rdata_i & ~bit_mask(r.bit_sel);
        end
        next_r.pc = r.pc + PC_W'(1);
        next_r.done = 1'b1;
        next_r.busy = 1'b0;
        next_r.st = ST_IDLE;
      end
      default: next_r = STATE_RESET; // illegal code recovers to reset
    endcase
  end

  // the one register bank
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r <= STATE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign busy_o = r.busy;
  assign done_o = r.done;
  assign pc_o = r.pc;
  assign status_o = r.flags;
  assign wr_en_o = r.wr_en;
  assign wr_idx_o = r.wr_idx;
  assign wr_data_o = r.wr_data;
  assign io_rd_o = r.io_rd;
  assign io_wr_o = r.io_wr;
  assign io_addr_o = r.io_addr;
  assign io_wdata_o = r.io_wdata;

  // checks; an issue counts only when the slice is idle
  logic acc; // instruction taken this cycle
  assign acc = op_valid_i && !busy_o;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_fall_through;
    acc && is_branch(op_i) && !branch_cond(op_i, status_o) && !flags_we_i
      |=> !busy_o && done_o && pc_o == $past(pc_o) + PC_W'(1) && status_o == $past(status_o);
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("untaken branch misbehaved");

  property p_taken;
    acc && is_branch(op_i) && branch_cond(op_i, status_o) && !flags_we_i
      |=> busy_o && !done_o ##1 done_o && !busy_o
      && pc_o == pc_target($past(pc_o, 2), $past(offset_i, 2));
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch target or timing wrong");

  property p_signed_ge;
    acc && op_i == OP_BRANCH_SIGNED_GE |=> busy_o == !($past(status_o[FLAG_N] ^ status_o[FLAG_V]));
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed ge decision wrong");

  property p_signed_less;
    acc && op_i == OP_BRANCH_SIGNED_LESS |=> busy_o == $past(status_o[FLAG_N] ^ status_o[FLAG_V]);
  endproperty
  a_signed_less: assert property (p_signed_less) else $error("signed less decision wrong");

  property p_half_one;
    acc && op_i == OP_BRANCH_HALFCARRY_ONE |=> busy_o == $past(status_o[FLAG_H]);
  endproperty
  a_half_one: assert property (p_half_one) else $error("half carry one decision wrong");

  property p_half_zero;
    acc && op_i == OP_BRANCH_HALFCARRY_ZERO |=> busy_o == !$past(status_o[FLAG_H]);
  endproperty
  a_half_zero: assert property (p_half_zero) else $error("half carry zero decision wrong");

  property p_transfer_one;
    acc && op_i == OP_BRANCH_TRANSFER_FLAG_ONE |=> busy_o == $past(status_o[FLAG_T]);
  endproperty
  a_transfer_one: assert property (p_transfer_one) else $error("transfer branch wrong");

  property p_irq_on;
    acc && op_i == OP_BRANCH_IRQ_ON |=> busy_o == $past(status_o[FLAG_I]);
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq on branch wrong");

  property p_irq_off;
    acc && op_i == OP_BRANCH_IRQ_OFF |=> busy_o == !$past(status_o[FLAG_I]);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq off branch wrong");

  property p_io_set;
    acc && op_i == OP_IO_BIT_SET |=> io_rd_o && !io_wr_o
      ##1 io_wr_o && done_o && io_wdata_o == ($past(io_rdata_i) | bit_mask($past(bit_sel_i, 2)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");

  property p_io_clear;
    acc && op_i == OP_IO_BIT_CLEAR |=> io_rd_o
      ##1 io_wr_o && io_wdata_o == ($past(io_rdata_i) & ~bit_mask($past(bit_sel_i, 2)));
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");

  property p_lsl;
    acc && op_i == OP_LOGICAL_LEFT_SHIFT |=> wr_en_o
      && wr_data_o == {$past(work_data_i[6:0]), 1'b0} && status_o[FLAG_C] == $past(work_data_i[7]);
  endproperty
  a_lsl: assert property (p_lsl) else $error("left shift wrong");

  property p_rol;
    acc && op_i == OP_ROTATE_LEFT_VIA_CARRY |=> wr_en_o
      && wr_data_o == {$past(work_data_i[6:0]), $past(status_o[FLAG_C])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");

  property p_ror;
    acc && op_i == OP_ROTATE_RIGHT_VIA_CARRY |=> wr_en_o
      && wr_data_o == {$past(status_o[FLAG_C]), $past(work_data_i[7:1])}
      && status_o[FLAG_C] == $past(work_data_i[0]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");

  property p_bst;
    acc && op_i == OP_BIT_TO_TRANSFER_FLAG && !flags_we_i
      |=> status_o[FLAG_T] == $past(work_data_i[bit_sel_i])
      && status_o[5:0] == $past(status_o[5:0]) && status_o[7] == $past(status_o[7]);
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");

  property p_swap;
    acc && op_i == OP_NIBBLE_SWAP |=> wr_en_o
      && wr_data_o == {$past(work_data_i[3:0]), $past(work_data_i[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  c_taken: cover property (acc && is_branch(op_i) ##1 busy_o ##1 done_o);
  c_io: cover property (acc && op_i == OP_IO_BIT_SET ##2 io_wr_o);
  c_back: cover property (acc && op_i == OP_ROTATE_LEFT_VIA_CARRY ##1 acc);

endmodule : bbu_top

// ---- verif/bbu_top_test.sv ----
// self-checking bench for the branch and bit operation slice
module bbu_top_test
  import bbu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // clock and reset, reset held low from time zero
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  // instruction issue
  logic op_valid_i = 1'b0;
  bbu_op_t op_i = OP_BRANCH_CARRY_CLEAR;
  logic [OFS_W-1:0] offset_i = '0;
  logic [2:0] bit_sel_i = '0;
  logic [4:0] dst_idx_i = '0;
  logic [DATA_W-1:0] work_data_i = '0;
  logic [4:0] io_addr_i = '0;
  // io read data and outside flag loads
  logic [DATA_W-1:0] io_rdata_i = '0;
  logic flags_we_i = 1'b0;
  logic [DATA_W-1:0] flags_wdata_i = '0;
  // design outputs
  logic busy_o;
  logic done_o;
  logic [PC_W-1:0] pc_o;
  logic [DATA_W-1:0] status_o;
  logic wr_en_o;
  logic [4:0] wr_idx_o;
  logic [DATA_W-1:0] wr_data_o;
  logic io_rd_o;
  logic io_wr_o;
  logic [4:0] io_addr_o;
  logic [DATA_W-1:0] io_wdata_o;

  // bench bookkeeping and reference state
  int errors = 0;
  int checks_done = 0;
  int m_pc = 0; // model program counter
  logic [7:0] m_fl = 8'h00; // model status flags

  // 200 MHz core clock
  always #2.5 core_clk_i = ~core_clk_i;

  bbu_top dut_u (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .op_valid_i(op_valid_i),
    .op_i(op_i),
    .offset_i(offset_i),
    .bit_sel_i(bit_sel_i),
    .dst_idx_i(dst_idx_i),
    .work_data_i(work_data_i),
    .io_addr_i(io_addr_i),
    .io_rdata_i(io_rdata_i),
    .flags_we_i(flags_we_i),
    .flags_wdata_i(flags_wdata_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .pc_o(pc_o),
    .status_o(status_o),
    .wr_en_o(wr_en_o),
    .wr_idx_o(wr_idx_o),
    .wr_data_o(wr_data_o),
    .io_rd_o(io_rd_o),
    .io_wr_o(io_wr_o),
    .io_addr_o(io_addr_o),
    .io_wdata_o(io_wdata_o)
  );

  // one comparison; case inequality so an unknown never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run, shared with the watchdog
  task automatic close_out();
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // outside load of the whole flag byte, seen one cycle later
  task automatic load_flags(input logic [7:0] v);
    @(posedge core_clk_i);
    flags_we_i <= 1'b1;
    flags_wdata_i <= v;
    @(posedge core_clk_i);
    flags_we_i <= 1'b0;
    #1;
    chk(status_o, v);
    m_fl = v;
  endtask : load_flags

  // issue one instruction, run the model beside it and compare all results;
  // poke re-issues a flag set while the slice is busy, which must be ignored
  task automatic run_op(input bbu_op_t op, input logic [6:0] ofs, input logic [2:0] bsel,
                        input logic [7:0] data, input bit poke);
    logic [4:0] idx;
    logic [4:0] addr;
    logic [7:0] iod;
    logic [7:0] res;
    logic [7:0] f;
    logic c;
    logic taken;
    int code;
    int cyc;
    int exp_cyc;
    bit io;
    idx = 5'($urandom);
    addr = 5'($urandom);
    iod = 8'($urandom);
    code = int'(op);
    io = (code == 16 || code == 17);
    res = data;
    f = m_fl;
    c = 1'b0;
    taken = 1'b0;
    // reference behaviour
    case (op)
      OP_BRANCH_CARRY_CLEAR: taken = !f[FLAG_C];
      OP_BRANCH_UNSIGNED_LOWER: taken = f[FLAG_C];
      OP_BRANCH_NEGATIVE: taken = f[FLAG_N];
      OP_BRANCH_POSITIVE: taken = !f[FLAG_N];
      OP_BRANCH_SIGNED_GE: taken = (f[FLAG_N] == f[FLAG_V]);
      OP_BRANCH_SIGNED_LESS: taken = (f[FLAG_N] != f[FLAG_V]);
      OP_BRANCH_HALFCARRY_ONE: taken = f[FLAG_H];
      OP_BRANCH_HALFCARRY_ZERO: taken = !f[FLAG_H];
      OP_BRANCH_TRANSFER_FLAG_ONE: taken = f[FLAG_T];
      OP_BRANCH_IRQ_ON: taken = f[FLAG_I];
      OP_BRANCH_IRQ_OFF: taken = !f[FLAG_I];
      OP_IO_BIT_SET: res = iod | (8'h01 << bsel);
      OP_IO_BIT_CLEAR: res = iod & ~(8'h01 << bsel);
      OP_LOGICAL_LEFT_SHIFT: {c, res} = {data, 1'b0};
      OP_LOGICAL_RIGHT_SHIFT: {res, c} = {1'b0, data};
      OP_ROTATE_LEFT_VIA_CARRY: {c, res} = {data, f[FLAG_C]};
      OP_ROTATE_RIGHT_VIA_CARRY: {res, c} = {f[FLAG_C], data};
      OP_ARITHMETIC_RIGHT_SHIFT: {res, c} = {data[7], data};
      OP_NIBBLE_SWAP: res = {data[3:0], data[7:4]};
      OP_STATUS_FLAG_SET: f[bsel] = 1'b1;
      OP_STATUS_FLAG_CLEAR: f[bsel] = 1'b0;
      OP_BIT_TO_TRANSFER_FLAG: f[FLAG_T] = data[bsel];
      default: ;
    endcase
    // shifts and rotates rebuild zero, carry, negative and overflow
    if (code >= 18 && code <= 22)
    begin
      f[FLAG_Z] = (res == 8'h00);
      f[FLAG_C] = c;
      f[FLAG_N] = res[7];
      f[FLAG_V] = res[7] ^ c;
    end
    // expected length; unknown codes never retire
    if ((code > 10 && code < 16) || code > 26)
      exp_cyc = 0;
    else if (code <= 10)
      exp_cyc = taken ? 2 : 1;
    else
      exp_cyc = io ? 2 : 1;
    // drive the issue cycle
    @(posedge core_clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    offset_i <= ofs;
    bit_sel_i <= bsel;
    dst_idx_i <= idx;
    work_data_i <= data;
    io_addr_i <= addr;
    io_rdata_i <= iod;
    // taking edge; a poke lands in the busy cycle
    @(posedge core_clk_i);
    op_valid_i <= poke;
    if (poke)
    begin
      op_i <= OP_STATUS_FLAG_SET;
      bit_sel_i <= 3'h0;
    end
    // results of the taking edge have settled here: that is cycle one
    #1;
    cyc = 1;
    // bounded wait for retirement
    while (done_o !== 1'b1 && cyc < 4)
    begin
      if (cyc == 1 && exp_cyc == 2)
        chk(busy_o, 1);
      if (cyc == 1 && io)
      begin
        chk(io_rd_o, 1);
        chk(io_addr_o, addr);
      end
      @(posedge core_clk_i);
      op_valid_i <= 1'b0;
      #1;
      cyc++;
    end
    chk((done_o === 1'b1) ? cyc : 0, exp_cyc);
    if (exp_cyc == 0)
      m_pc = m_pc;
    else if (code <= 10 && taken)
      m_pc = (m_pc + int'($signed(ofs)) + 1) & 32'h0000FFFF;
    else
      m_pc = (m_pc + 1) & 32'h0000FFFF;
    m_fl = f;
    chk(pc_o, m_pc);
    chk(status_o, m_fl);
    if (io)
    begin
      chk(io_wr_o, 1);
      chk(io_addr_o, addr);
      chk(io_wdata_o, res);
    end
    // write back for shifts, rotates and swap
    if (code >= 18 && code <= 23)
    begin
      chk(wr_en_o, 1);
      chk(wr_idx_o, idx);
      chk(wr_data_o, res);
    end
  endtask : run_op

  // main sequence
  initial
  begin
    void'($urandom(32'hCFF42ED3));
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk(pc_o, 16'h0000);
    chk(status_o, 8'h00);
    // every code, listed or not, with random flags and operands
    for (int rep = 0; rep < 12; rep++)
    begin
      for (int c = 0; c < 32; c++)
      begin
        if (c[0] == 1'b0)
          load_flags(8'($urandom));
        run_op(bbu_op_t'(5'(c)), 7'($urandom), 3'($urandom), 8'($urandom), 1'b0);
      end
    end
    // an issue during a taken branch must leave no trace
    load_flags(8'h00);
    run_op(OP_BRANCH_CARRY_CLEAR, 7'h05, 3'h0, 8'h00, 1'b1);
    // extreme offsets, most negative and most positive
    run_op(OP_BRANCH_IRQ_OFF, 7'h40, 3'h0, 8'h00, 1'b0);
    run_op(OP_BRANCH_IRQ_OFF, 7'h3F, 3'h0, 8'h00, 1'b0);
    // left shift out the only set bit: zero and carry both rise; the arithmetic right shift sets carry and negative
    run_op(OP_LOGICAL_LEFT_SHIFT, 7'h00, 3'h0, 8'h80, 1'b0);
    run_op(OP_ARITHMETIC_RIGHT_SHIFT, 7'h00, 3'h0, 8'h81, 1'b0);
    close_out();
  end

  // watchdog, well past the expected run of about sixteen hundred cycles
  initial
  begin
    #60000;
    errors++;
    close_out();
  end

endmodule : bbu_top_test
